/* File: spim_consts.svh */
// Register offsets, field positions, reset values and timing counts for the SPI master status block
`ifndef SPIM_CONSTS_SVH
`define SPIM_CONSTS_SVH
`define SPIM_OFF_PRESCALER 8'hD2
`define SPIM_OFF_FLAGS 8'hD3
`define SPIM_OFF_TXHOLD 8'hD4
`define SPIM_OFF_RXHOLD 8'hD5
`define SPIM_OFF_IRQEN 8'hD7
`define SPIM_RST_PRESCALER 8'h04
`define SPIM_RST_FLAGS 8'h02
`define SPIM_RST_IRQEN 8'h00
`define SPIM_MASK_PRESCALER 8'hFC
`define SPIM_MASK_IRQEN 8'h0F
`define SPIM_BIT_RX_FULL 0
`define SPIM_BIT_TX_EMPTY 1
`define SPIM_BIT_OVERRUN 2
`define SPIM_BIT_TX_END 3
`define SPIM_BIT_BUSY 4
`define SPIM_BIT_DIVIDE_BY_128_SELECT 7
`define SPIM_BIT_DIVIDE_BY_64_SELECT 6
`define SPIM_BIT_DIVIDE_BY_32_SELECT 5
`define SPIM_BIT_DIVIDE_BY_16_SELECT 4
`define SPIM_BIT_DIVIDE_BY_8_SELECT 3
`define SPIM_BIT_DIVIDE_BY_4_SELECT 2
`define SPIM_HALF_128 8'h40
`define SPIM_HALF_64 8'h20
`define SPIM_HALF_32 8'h10
`define SPIM_HALF_16 8'h08
`define SPIM_HALF_8 8'h04
`define SPIM_HALF_4 8'h02
`define SPIM_BITS_PER_BYTE 4'h8
`endif

/* File: spim_pkg.sv */
// Types shared by the SPI master status block
package spim_pkg;
   typedef enum logic [1:0] {
      SPIM_IDLE,
      SPIM_SHIFT,
      SPIM_DONE
   } spim_state_e;
endpackage

/* File: spim_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ns
module spim_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Fill side
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   // Drain side
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW-1:0] wrPtr;
      logic [AW-1:0] rdPtr;
      logic [AW:0] count;
   } spim_fifo_s;
   spim_fifo_s st_r;
   spim_fifo_s st_nxt;
   logic [WIDTH-1:0] mem [DEPTH];
   logic push;
   logic pop;

   assign inReady = (st_r.count != (AW+1)'(DEPTH));
   assign outValid = (st_r.count != '0);
   assign outData = mem[st_r.rdPtr];
   assign push = inValid && inReady;
   assign pop = outValid && outReady;

   always_comb begin
      st_nxt = st_r;
      if (push) begin
         st_nxt.wrPtr = (st_r.wrPtr == AW'(DEPTH - 1)) ? '0 : st_r.wrPtr + 1'b1;
      end
      if (pop) begin
         st_nxt.rdPtr = (st_r.rdPtr == AW'(DEPTH - 1)) ? '0 : st_r.rdPtr + 1'b1;
      end
      if (push && !pop) begin
         st_nxt.count = st_r.count + 1'b1;
      end else if (pop && !push) begin
         st_nxt.count = st_r.count - 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Storage has no reset; only the pointers and the count need a defined start
   always_ff @(posedge core_clk) begin
      if (push) begin
         mem[st_r.wrPtr] <= inData;
      end
   end
endmodule

/* File: spim_status_clkdiv.sv */
// SPI master flags, interrupt enables, clock prescaler and byte engine
//
// Contract
// RULE_01: Transmission-end interrupt only when its enable set
// RULE_02: Overrun interrupt only when its enable set
// RULE_03: Transmit-empty interrupt only when its enable set
// RULE_04: Interrupt-enable register resets to zero
// RULE_05: Prescaler bits 7..5 divide by 128/64/32
// RULE_06: Prescaler bits 4..2 divide by 16/8/4
// RULE_07: Prescaler resets to divide-by-four
// RULE_08: Busy status bit 4 while shifting
// RULE_09: Transmission end sets flag bit 3
// RULE_10: Status read clears transmission-end flag
// RULE_11: Transmit-empty set when holding loads shifter
// RULE_12: Holding write clears transmit-empty; status read doesn't
// RULE_13: Receive-full set when receive holding filled
// RULE_14: Receive holding read clears receive-full
// RULE_15: Status resets to transmit-empty only
// RULE_16: New byte while receive full sets overrun
// RULE_17: Receive-full interrupt only when its enable set
// RULE_18: Firmware sets one divide bit; largest wins
// RULE_19: One interrupt output for all enabled sources
// RULE_20: Status read clears overrun flag
`timescale 1ns/1ns
`include "spim_consts.svh"
module spim_status_clkdiv
   import spim_pkg::*;
#(
   parameter int FIFO_DEPTH = 8
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Special-function register port
   input wire logic [7:0] sfrAddr,
   input wire logic sfrWr,
   input wire logic sfrRd,
   input wire logic [7:0] sfrWrData,
   output logic [7:0] sfrRdData,
   // Processor interrupt
   output logic spiIrq,
   // Serial link
   output logic serialClockOut,
   output logic serialDataOut,
   input wire logic serialDataIn,
   // Received bytes as a stream
   output logic rxStreamValid,
   input wire logic rxStreamReady,
   output logic [7:0] rxStreamData
);
   typedef struct packed {
      logic [7:0] prescaler;
      logic [3:0] irqEn;
      logic txEmpty;
      logic rxFull;
      logic overrun;
      logic txEnd;
      logic [7:0] txHold;
      logic [7:0] rxHold;
      logic [7:0] shiftReg;
      logic [3:0] bitCnt;
      logic [7:0] divCnt;
      logic sclk;
      logic [7:0] rdData;
      spim_state_e state;
   } spim_core_s;

   spim_core_s st_r;
   spim_core_s st_nxt;
   logic fifoInReady;
   logic [7:0] fifoOutData;
   logic fifoOutValid;
   logic rdFlags;
   logic rdRx;
   logic byteDone;

   // Largest selected divisor wins; none selected falls back to the smallest
   function automatic logic [7:0] halfPeriod(input logic [7:0] p);
      if (p[`SPIM_BIT_DIVIDE_BY_128_SELECT]) return `SPIM_HALF_128; // RULE_05 RULE_18
      else if (p[`SPIM_BIT_DIVIDE_BY_64_SELECT]) return `SPIM_HALF_64; // RULE_05
      else if (p[`SPIM_BIT_DIVIDE_BY_32_SELECT]) return `SPIM_HALF_32; // RULE_05
      else if (p[`SPIM_BIT_DIVIDE_BY_16_SELECT]) return `SPIM_HALF_16; // RULE_06
      else if (p[`SPIM_BIT_DIVIDE_BY_8_SELECT]) return `SPIM_HALF_8; // RULE_06
      else return `SPIM_HALF_4; // RULE_06
   endfunction

   function automatic logic [7:0] flagsWord(input spim_core_s s);
      logic [7:0] w;
      w = 8'h00;
      w[`SPIM_BIT_BUSY] = (s.state != SPIM_IDLE); // RULE_08
      w[`SPIM_BIT_TX_END] = s.txEnd;
      w[`SPIM_BIT_OVERRUN] = s.overrun;
      w[`SPIM_BIT_TX_EMPTY] = s.txEmpty;
      w[`SPIM_BIT_RX_FULL] = s.rxFull;
      return w;
   endfunction

   assign rdFlags = sfrRd && (sfrAddr == `SPIM_OFF_FLAGS);
   assign rdRx = sfrRd && (sfrAddr == `SPIM_OFF_RXHOLD);
   assign byteDone = (st_r.state == SPIM_DONE);

   always_comb begin
      st_nxt = st_r;
      // Read data captured on the read strobe, answered next cycle
      st_nxt.rdData = 8'h00;
      if (sfrRd) begin
         case (sfrAddr)
            `SPIM_OFF_PRESCALER: st_nxt.rdData = st_r.prescaler;
            `SPIM_OFF_FLAGS: st_nxt.rdData = flagsWord(st_r);
            `SPIM_OFF_TXHOLD: st_nxt.rdData = st_r.txHold;
            `SPIM_OFF_RXHOLD: st_nxt.rdData = st_r.rxHold;
            `SPIM_OFF_IRQEN: st_nxt.rdData = {4'h0, st_r.irqEn}; // RULE_04
            default: st_nxt.rdData = 8'h00;
         endcase
      end
      // Clears first, so that hardware sets below win in the same cycle
      if (rdFlags) begin
         st_nxt.txEnd = 1'b0; // RULE_10
         st_nxt.overrun = 1'b0; // RULE_20
      end
      if (rdRx) begin
         st_nxt.rxFull = 1'b0; // RULE_14
      end
      if (sfrWr) begin
         case (sfrAddr)
            `SPIM_OFF_PRESCALER: st_nxt.prescaler = sfrWrData & `SPIM_MASK_PRESCALER;
            `SPIM_OFF_IRQEN: st_nxt.irqEn = sfrWrData[3:0];
            `SPIM_OFF_TXHOLD: begin
               st_nxt.txHold = sfrWrData;
               st_nxt.txEmpty = 1'b0; // RULE_12
            end
            default: ;
         endcase
      end
      case (st_r.state)
         SPIM_IDLE: begin
            st_nxt.sclk = 1'b0;
            st_nxt.divCnt = 8'h00;
            if (!st_r.txEmpty) begin
               st_nxt.shiftReg = st_r.txHold;
               st_nxt.txEmpty = 1'b1; // RULE_11
               st_nxt.bitCnt = 4'h0;
               st_nxt.state = SPIM_SHIFT;
            end
         end
         SPIM_SHIFT: begin
            if (st_r.divCnt == halfPeriod(st_r.prescaler) - 8'h01) begin
               st_nxt.divCnt = 8'h00;
               st_nxt.sclk = !st_r.sclk;
               if (!st_r.sclk) begin
                  // Rising edge samples the input and shifts out the next bit; falling edge only checks for the end
                  st_nxt.shiftReg = {st_r.shiftReg[6:0], serialDataIn};
                  st_nxt.bitCnt = st_r.bitCnt + 4'h1;
               end else if (st_r.bitCnt == `SPIM_BITS_PER_BYTE) begin
                  st_nxt.state = SPIM_DONE;
               end
            end else begin
               st_nxt.divCnt = st_r.divCnt + 8'h01;
            end
         end
         SPIM_DONE: begin
            st_nxt.txEnd = 1'b1; // RULE_09
            st_nxt.rxHold = st_r.shiftReg;
            st_nxt.rxFull = 1'b1; // RULE_13
            if (st_r.rxFull && !rdRx) begin
               st_nxt.overrun = 1'b1; // RULE_16
            end
            st_nxt.state = SPIM_IDLE;
         end
         default: st_nxt.state = SPIM_IDLE;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
         st_r.prescaler <= `SPIM_RST_PRESCALER; // RULE_07
         st_r.irqEn <= 4'h0; // RULE_04
         st_r.txEmpty <= 1'b1; // RULE_15
         st_r.state <= SPIM_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Received bytes also flow to a stream; a full FIFO drops the byte, the
   // holding register still reports it; overrun is set only when receive-full is still set
   spim_fifo #(
      .WIDTH(8),
      .DEPTH(FIFO_DEPTH)
   ) u_rxFifo (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .inValid(byteDone),
      .inReady(fifoInReady),
      .inData(st_r.shiftReg),
      .outValid(fifoOutValid),
      .outReady(rxStreamReady),
      .outData(fifoOutData)
   );

   assign rxStreamValid = fifoOutValid;
   assign rxStreamData = fifoOutData;
   assign sfrRdData = st_r.rdData;
   assign serialClockOut = st_r.sclk;
   assign serialDataOut = st_r.shiftReg[7];
   assign spiIrq = (st_r.txEnd && st_r.irqEn[`SPIM_BIT_TX_END]) // RULE_01 RULE_19
      || (st_r.overrun && st_r.irqEn[`SPIM_BIT_OVERRUN]) // RULE_02
      || (st_r.txEmpty && st_r.irqEn[`SPIM_BIT_TX_EMPTY]) // RULE_03
      || (st_r.rxFull && st_r.irqEn[`SPIM_BIT_RX_FULL]); // RULE_17
endmodule

/* File: spim_status_clkdiv_assertions.sv */
// Port assertions for the SPI master status block
`timescale 1ns/1ns
`include "spim_consts.svh"
module spim_status_clkdiv_assertions (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Register port and interrupt
   input wire logic [7:0] sfrAddr,
   input wire logic sfrWr,
   input wire logic sfrRd,
   input wire logic [7:0] sfrWrData,
   input wire logic [7:0] sfrRdData,
   input wire logic spiIrq,
   // Link and stream
   input wire logic serialClockOut,
   input wire logic serialDataOut,
   input wire logic serialDataIn,
   input wire logic rxStreamValid,
   input wire logic rxStreamReady,
   input wire logic [7:0] rxStreamData
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   sequence rdFlags;
      sfrRd && !sfrWr && sfrAddr == `SPIM_OFF_FLAGS;
   endsequence
   reserved_irqen_a: assert property (sfrRd && sfrAddr == `SPIM_OFF_IRQEN
      |=> sfrRdData[7:4] == 4'h0) else $error("enable upper bits set");
   presc_low_a: assert property (sfrRd && sfrAddr == `SPIM_OFF_PRESCALER
      |=> sfrRdData[1:0] == 2'h0) else $error("prescaler low bits set");
   flags_high_a: assert property (rdFlags |=> sfrRdData[7:5] == 3'h0)
      else $error("flag upper bits set");
   rd_idle_a: assert property (!sfrRd |=> sfrRdData == 8'h00)
      else $error("read data not idle");
   irq_quiet_a: assert property (sfrWr && sfrAddr == `SPIM_OFF_IRQEN
      && sfrWrData[3:0] == 4'h0 |=> !spiIrq) else $error("irq with no enables");
   sclk_high_a: assert property ($rose(serialClockOut) |=> serialClockOut)
      else $error("clock high too short");
   stream_hold_a: assert property (rxStreamValid && !rxStreamReady
      |=> rxStreamValid && $stable(rxStreamData)) else $error("stream dropped");
   txempty_keep_a: assert property (rdFlags ##1 (sfrRdData[1] && !sfrWr) ##1 rdFlags
      |=> sfrRdData[1]) else $error("status read cleared tx empty");
endmodule

/* File: spim_slave_model.sv */
// Behavioural serial slave returning a preset byte
`timescale 1ns/1ns
module spim_slave_model (
   // Link
   input wire logic sclk,
   output logic miso,
   // Control
   input wire logic load,
   input wire logic [7:0] reply
);
   logic [7:0] sh;
   // Shifts on the falling edge so the bit is steady at the sampling edge
   always @(negedge sclk or posedge load)
      if (load)
         sh <= reply;
      else
         sh <= {sh[6:0], ~sh[0]};
   assign miso = sh[7];
endmodule

/* File: tb_spim_status_clkdiv.sv */
// Self-checking bench for the SPI master status block
`timescale 1ns/1ns
`include "spim_consts.svh"
module tb_spim_status_clkdiv;
   logic core_clk, rst_n, sfrWr, sfrRd, miso, ld, rdy, sclk, mosi, irq, vld;
   logic [7:0] addr, wd, rdd, sd, rep, d, fx;
   int fails = 0, num_checks = 0, cyc = 0, rises = 0, last = 0, per = 0, r0;
   logic sclkD = 1'b0;
   // Serial output bits seen at each rising serial clock, MSB first
   logic mosiD = 1'b0;
   logic [7:0] txSeen = 8'h00;
   logic [23:0] rows [6] = '{24'hD2FFFC, 24'hD7FF0F, 24'hD70000, 24'hD0FF00, 24'hD3FF02,
      24'hD20404};
   spim_status_clkdiv u_dut (.core_clk(core_clk), .rst_n(rst_n), .sfrAddr(addr),
      .sfrWr(sfrWr), .sfrRd(sfrRd), .sfrWrData(wd), .sfrRdData(rdd), .spiIrq(irq),
      .serialClockOut(sclk), .serialDataOut(mosi), .serialDataIn(miso),
      .rxStreamValid(vld), .rxStreamReady(rdy), .rxStreamData(sd));
   spim_slave_model u_slv (.sclk(sclk), .miso(miso), .load(ld), .reply(rep));
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   task automatic final_report;
      $display("Checks %0d, mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] e, g, input string n);
      num_checks++;
      if (g !== e) begin
         fails++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, v);
      @(posedge core_clk);
      addr <= a;
      wd <= v;
      sfrWr <= 1'b1;
      @(posedge core_clk);
      sfrWr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge core_clk);
      addr <= a;
      sfrRd <= 1'b1;
      @(posedge core_clk);
      sfrRd <= 1'b0;
      @(negedge core_clk);
      d = rdd;
   endtask
   // Edge watcher and hang guard, sampled mid-cycle where outputs are settled
   always @(negedge core_clk) begin
      cyc++;
      if (sclk && !sclkD) begin
         per = cyc - last;
         last = cyc;
         rises++;
         // The bit stood during the low phase; the design moves on at the rise
         txSeen = {txSeen[6:0], mosiD};
      end
      sclkD = sclk;
      mosiD = mosi;
      if (cyc == 20000) begin
         fails++;
         final_report;
      end
   end
   initial begin
      {rst_n, sfrWr, sfrRd, ld, rdy} = 5'h00;
      {addr, wd, rep} = 24'h000000;
      repeat (16) @(posedge core_clk);
      rst_n <= 1'b1;
      rd(`SPIM_OFF_PRESCALER);
      chk(8'h04, d, "prescaler");
      rd(`SPIM_OFF_FLAGS);
      chk(8'h02, d, "flags");
      rd(`SPIM_OFF_IRQEN);
      chk(8'h00, d, "enables");
      foreach (rows[r]) begin
         wr(rows[r][23:16], rows[r][15:8]);
         rd(rows[r][23:16]);
         chk(rows[r][7:0], d, "register");
      end
      // Nine bytes with no draining: the ninth meets a full buffer
      for (int i = 0; i < 9; i++) begin
         @(posedge core_clk);
         rep <= 8'h5A ^ 8'(i);
         ld <= 1'b1;
         wr(`SPIM_OFF_PRESCALER, 8'h80 >> (i % 6));
         ld <= 1'b0;
         r0 = rises;
         wr(`SPIM_OFF_TXHOLD, 8'h96);
         @(posedge core_clk);
         rd(`SPIM_OFF_FLAGS);
         chk(8'h12 | 8'(i > 0), d, "busy flags");
         while (rises < r0 + 8)
            @(negedge core_clk);
         chk(8'h80 >> (i % 6), 8'(per), "period");
         chk(8'h96, txSeen, "serial out");
         repeat ((128 >> (i % 6)) / 2 + 3) @(negedge core_clk);
         fx = (i == 0) ? 8'h0B : 8'h0F;
         for (int j = 0; j < 4; j++) begin
            wr(`SPIM_OFF_IRQEN, 8'h01 << j);
            @(negedge core_clk);
            chk({7'h00, fx[j]}, {7'h00, irq}, "irq");
         end
         wr(`SPIM_OFF_IRQEN, 8'h00);
         rd(`SPIM_OFF_FLAGS);
         chk(fx, d, "end flags");
         rd(`SPIM_OFF_FLAGS);
         chk(8'h03, d, "cleared flags");
      end
      rd(`SPIM_OFF_RXHOLD);
      rd(`SPIM_OFF_FLAGS);
      chk(8'h02, d, "rx read");
      @(posedge core_clk);
      rdy <= 1'b1;
      for (int k = 0; k < 9; k++) begin
         @(negedge core_clk);
         chk(8'(k < 8), {7'h00, vld}, "stream valid");
         if (k < 8)
            chk(8'h5A ^ 8'(k), sd, "stream data");
      end
      // Reset in mid-run must bring prescaler, enables and flags back to their reset values
      wr(`SPIM_OFF_PRESCALER, 8'h20);
      wr(`SPIM_OFF_IRQEN, 8'h0F);
      @(posedge core_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      rd(`SPIM_OFF_PRESCALER);
      chk(8'h04, d, "prescaler after reset");
      rd(`SPIM_OFF_IRQEN);
      chk(8'h00, d, "enables after reset");
      rd(`SPIM_OFF_FLAGS);
      chk(8'h02, d, "flags after reset");
      final_report;
   end
endmodule
bind spim_status_clkdiv spim_status_clkdiv_assertions u_chk (.*);
